// ### hw/ddr_sram_pkg.sv
// Constants, field layouts and carrier types shared by the burst SRAM write-side design.
// What this block does
// R1: Second burst address inverts first address LSB.
// R2: Powers up deselected with data outputs tristated.
// R3: 18-bit, both selects low: write all bits.
// R4: 18-bit, select 0 only: write bits 8..0.
// R5: 18-bit, select 1 only: write bits 17..9.
// R6: 18-bit, both selects high: write nothing.
// R7: Selects sampled separately for each data beat.
// R8: 36-bit, all selects low: write all bits.
// R9: 36-bit, selects 0/1 gate lanes 0/1.
// R10: 36-bit, select 2 gates bits 26..18.
// R11: 36-bit, select 3 gates bits 35..27.
// R12: 36-bit, all selects high: no update.
// R13: Controller starts write with load, rw low.
// R14: Beat one at next K, beat two at K-bar.
// R15: Beat two with its mask goes to second address.
package ddr_sram_pkg;

    // Array geometry: a small flip-flop array stands in for the full core.
    localparam int ADDR_W   = 4;
    localparam int DEPTH    = 16;
    localparam int LANE_W   = 9;
    localparam int LANES    = 4;
    localparam int LANES_18 = 2;
    localparam int WORD_W   = LANE_W * LANES;

    // Reference clock.
    localparam int CLK_PERIOD_NS = 20;

    // AXI4-Lite register map, byte addresses.
    localparam int          AXI_ADDR_W   = 8;
    localparam logic [7:0]  CTRL_OFS     = 8'h00;
    localparam logic [7:0]  STATUS_OFS   = 8'h04;
    localparam logic [7:0]  PEEK_IDX_OFS = 8'h08;
    localparam logic [7:0]  PEEK_DAT_OFS = 8'h0C;
    localparam logic [1:0]  RESP_OKAY    = 2'h0;
    localparam logic [1:0]  RESP_SLVERR  = 2'h2;

    // Control register fields.
    localparam int          CTRL_ORG36_BIT = 0;
    localparam logic        CTRL_ORG36_RST = 1'b0;

    // Status register fields.
    localparam int          STAT_DESEL_BIT   = 0;
    localparam int          STAT_PEND2_BIT   = 1;
    localparam int          STAT_ORG36_BIT   = 2;
    localparam int          STAT_BEATS_LSB   = 8;
    localparam int          BEAT_CNT_W       = 16;

    // Pins driven by the memory controller.
    typedef struct packed {
        logic                k;
        logic                k_n;
        logic                transfer_load_n;
        logic                rw_n;
        logic [ADDR_W-1:0]   addr;
        logic [WORD_W-1:0]   d;
        logic [LANES-1:0]    byte_lane_write_select_n;
    } mem_pins_t;

    // One data beat headed for the array.
    typedef struct packed {
        logic [ADDR_W-1:0]   idx;
        logic [WORD_W-1:0]   data;
        logic [LANES-1:0]    sel_n;
    } beat_t;

    typedef enum logic {
        PH_IDLE,
        PH_SECOND
    } beat_phase_t;

endpackage

// ### hw/lane_merge.sv
// Byte-lane merge of one write beat into the stored word.
`timescale 1ns/1ps
`default_nettype none
module lane_merge
    import ddr_sram_pkg::*;
(
    // Mode and beat
    input  wire logic              org_36,
    input  wire beat_t             beat,
    // Array word
    input  wire logic [WORD_W-1:0] old_word,
    output logic      [WORD_W-1:0] new_word,
    output logic                   any_lane
);

    logic [LANES-1:0] lane_on;

    // In the 18-bit organisation the upper two selects do not exist, so their lanes never write.
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            assign lane_on[g] = ~beat.sel_n[g] & (org_36 | (g < LANES_18)); // R3 R4 R5 R8 R9 R10 R11
            assign new_word[g*LANE_W +: LANE_W] = lane_on[g] ? beat.data[g*LANE_W +: LANE_W]
                                                             : old_word[g*LANE_W +: LANE_W];
        end
    endgenerate

    assign any_lane = |lane_on; // R6 R12

endmodule // lane_merge
`default_nettype wire

// ### hw/ddr_sram_write.sv
// Write side of the two-word burst SRAM with byte-lane masking and an AXI4-Lite view.
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
module ddr_sram_write
    import ddr_sram_pkg::*;
(
    // Clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  rst_n,
    // Memory controller pins
    input  wire mem_pins_t             pins,
    output logic                       dq_oe,
    // AXI4-Lite write address and data
    input  wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [31:0]           s_axi_wdata,
    input  wire logic [3:0]            s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    // AXI4-Lite read
    input  wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [31:0]                s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready
);

    function automatic logic reg_known(input logic [AXI_ADDR_W-1:0] a);
        reg_known = (a == CTRL_OFS) || (a == STATUS_OFS) ||
                    (a == PEEK_IDX_OFS) || (a == PEEK_DAT_OFS);
    endfunction

    // Reset release.
    logic rst_s1_r;
    logic rst_sync_n;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1_r   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_s1_r   <= 1'b1;
            rst_sync_n <= rst_s1_r;
        end
    end

    // Pin synchronisers; only the second stage and the edge history are read.
    mem_pins_t pin_s1_r;
    mem_pins_t pin_s2_r;
    logic      k_prev_r;
    logic      kn_prev_r;
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            // K-bar idles high, so its copies start high and no false rise follows reset.
            pin_s1_r  <= '{k_n: 1'b1, default: '0};
            pin_s2_r  <= '{k_n: 1'b1, default: '0};
            k_prev_r  <= 1'b0;
            kn_prev_r <= 1'b1;
        end else begin
            pin_s1_r  <= pins;
            pin_s2_r  <= pin_s1_r;
            k_prev_r  <= pin_s2_r.k;
            kn_prev_r <= pin_s2_r.k_n;
        end
    end

    wire k_rise   = pin_s2_r.k & ~k_prev_r;
    wire kn_rise  = pin_s2_r.k_n & ~kn_prev_r;
    // The controller opens a write with load and read/write both low at a K rise.
    wire wr_load  = k_rise & ~pin_s2_r.transfer_load_n & ~pin_s2_r.rw_n; // R13
    wire any_load = k_rise & ~pin_s2_r.transfer_load_n;

    // Burst pipeline: stage A holds a loaded address awaiting its first beat,
    // stage B holds the burst awaiting its second beat on the K-bar rise.
    logic              a_valid_r;
    logic [ADDR_W-1:0] a_idx_r;
    beat_phase_t       phase_r;
    logic [ADDR_W-1:0] b_idx_r;
    logic              desel_r;
    logic              org36_r;

    wire beat0_go = k_rise & a_valid_r; // R14
    wire beat1_go = kn_rise & (phase_r == PH_SECOND) & ~beat0_go; // R14

    // Each beat carries the selects seen at its own edge.
    beat_t cur_beat;
    assign cur_beat.idx   = beat0_go ? a_idx_r : {b_idx_r[ADDR_W-1:1], ~b_idx_r[0]}; // R1 R15
    assign cur_beat.data  = pin_s2_r.d; // R14
    assign cur_beat.sel_n = pin_s2_r.byte_lane_write_select_n; // R7

    wire beat_go = beat0_go | beat1_go;

    logic [WORD_W-1:0] mem_r [DEPTH];
    logic [WORD_W-1:0] merged;
    logic              lane_hit;

    lane_merge u_merge (
        .org_36   (org36_r),
        .beat     (cur_beat),
        .old_word (mem_r[cur_beat.idx]),
        .new_word (merged),
        .any_lane (lane_hit)
    );

    // A beat with every select high leaves the word untouched.
    always_ff @(posedge ref_clk) begin
        if (beat_go && lane_hit) begin
            mem_r[cur_beat.idx] <= merged; // R3 R4 R5 R6 R8 R9 R10 R11 R12 R15
        end
    end

    logic [BEAT_CNT_W-1:0] beats_r;
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            a_valid_r <= 1'b0;
            a_idx_r   <= '0;
            phase_r   <= PH_IDLE;
            b_idx_r   <= '0;
            desel_r   <= 1'b1; // R2
            dq_oe     <= 1'b0; // R2
            beats_r   <= '0;
        end else begin
            dq_oe <= 1'b0; // R2
            if (k_rise) begin
                a_valid_r <= wr_load;
                a_idx_r   <= pin_s2_r.addr;
                desel_r   <= ~any_load;
            end
            if (beat0_go) begin
                phase_r <= PH_SECOND;
                b_idx_r <= a_idx_r;
            end else if (beat1_go) begin
                phase_r <= PH_IDLE;
            end
            if (beat_go) begin
                beats_r <= beats_r + 1'b1;
            end
        end
    end

    // Register bus: write channel.
    logic                  aw_got_r;
    logic                  w_got_r;
    logic [AXI_ADDR_W-1:0] awaddr_r;
    logic [31:0]           wdata_r;
    logic [3:0]            wstrb_r;
    logic [ADDR_W-1:0]     peek_idx_r;

    wire aw_take  = s_axi_awvalid & s_axi_awready;
    wire w_take   = s_axi_wvalid & s_axi_wready;
    wire wr_do    = aw_got_r & w_got_r & ~s_axi_bvalid;
    wire wr_known = reg_known(awaddr_r);

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
            aw_got_r      <= 1'b0;
            w_got_r       <= 1'b0;
            awaddr_r      <= '0;
            wdata_r       <= '0;
            wstrb_r       <= '0;
            org36_r       <= CTRL_ORG36_RST;
            peek_idx_r    <= '0;
        end else begin
            if (aw_take) begin
                aw_got_r      <= 1'b1;
                awaddr_r      <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (w_take) begin
                w_got_r      <= 1'b1;
                wdata_r      <= s_axi_wdata;
                wstrb_r      <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_do) begin
                aw_got_r     <= 1'b0;
                w_got_r      <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
                if (awaddr_r == CTRL_OFS && wstrb_r[0]) begin
                    org36_r <= wdata_r[CTRL_ORG36_BIT];
                end
                if (awaddr_r == PEEK_IDX_OFS && wstrb_r[0]) begin
                    peek_idx_r <= wdata_r[ADDR_W-1:0];
                end
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // Register bus: read channel.
    logic [31:0] status_word;
    logic [31:0] rd_word;
    assign status_word = {{(32-STAT_BEATS_LSB-BEAT_CNT_W){1'b0}}, beats_r, 5'h00,
                          org36_r, phase_r == PH_SECOND, desel_r};
    assign rd_word = (s_axi_araddr == CTRL_OFS)     ? {31'h0, org36_r} :
                     (s_axi_araddr == STATUS_OFS)   ? status_word :
                     (s_axi_araddr == PEEK_IDX_OFS) ? {{(32-ADDR_W){1'b0}}, peek_idx_r} :
                     (s_axi_araddr == PEEK_DAT_OFS) ? mem_r[peek_idx_r][31:0] : 32'h0;

    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= rd_word;
            s_axi_rresp   <= reg_known(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Helper state that only the checks below read.
    logic              chk_go_r;
    logic              chk_second_r;
    logic              chk_org_r;
    logic [ADDR_W-1:0] chk_idx_r;
    logic [WORD_W-1:0] chk_data_r;
    logic [WORD_W-1:0] chk_old_r;
    logic [LANES-1:0]  chk_sel_r;
    logic [ADDR_W-1:0] chk_first_r;
    always_ff @(posedge ref_clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            chk_go_r     <= 1'b0;
            chk_second_r <= 1'b0;
            chk_org_r    <= 1'b0;
            chk_idx_r    <= '0;
            chk_data_r   <= '0;
            chk_old_r    <= '0;
            chk_sel_r    <= '0;
            chk_first_r  <= '0;
        end else begin
            chk_go_r     <= beat_go;
            chk_second_r <= beat1_go;
            chk_org_r    <= org36_r;
            chk_idx_r    <= cur_beat.idx;
            chk_data_r   <= cur_beat.data;
            chk_old_r    <= mem_r[cur_beat.idx];
            chk_sel_r    <= cur_beat.sel_n;
            if (beat0_go) begin
                chk_first_r <= cur_beat.idx;
            end
        end
    end

    wire [WORD_W-1:0] chk_now = mem_r[chk_idx_r];

    chk_second_addr: assert property (@(posedge ref_clk) disable iff (!rst_sync_n) // R1
        beat1_go |-> cur_beat.idx == {chk_first_r[ADDR_W-1:1], ~chk_first_r[0]})
        else $error("second burst address is not the first with its LSB inverted");
    chk_outputs_off: assert property (@(posedge ref_clk) disable iff (!rst_sync_n) // R2
        desel_r && !k_rise |=> desel_r && !dq_oe)
        else $error("device left deselect or drove data without a load");
    chk_full_18: assert property (@(posedge ref_clk) disable iff (!rst_sync_n) // R3
        chk_go_r && !chk_org_r && chk_sel_r[1:0] == 2'h0 |-> chk_now[17:0] == chk_data_r[17:0])
        else $error("18-bit full write did not store all bits");
    chk_low_18: assert property (@(posedge ref_clk) disable iff (!rst_sync_n) // R4
        chk_go_r && !chk_org_r && chk_sel_r[1:0] == 2'h2
        |-> chk_now[8:0] == chk_data_r[8:0] && chk_now[17:9] == chk_old_r[17:9])
        else $error("18-bit low lane write disturbed the wrong bits");
    chk_high_18: assert property (@(posedge ref_clk) disable iff (!rst_sync_n) // R5
        chk_go_r && !chk_org_r && chk_sel_r[1:0] == 2'h1
        |-> chk_now[17:9] == chk_data_r[17:9] && chk_now[8:0] == chk_old_r[8:0])
        else $error("18-bit high lane write disturbed the wrong bits");
    chk_none_18: assert property (@(posedge ref_clk) disable iff (!rst_sync_n) // R6
        chk_go_r && !chk_org_r && chk_sel_r[1:0] == 2'h3 |-> chk_now[17:0] == chk_old_r[17:0])
        else $error("18-bit beat with no selects changed the word");
    chk_full_36: assert property (@(posedge ref_clk) disable iff (!rst_sync_n) // R8
        chk_go_r && chk_org_r && chk_sel_r == 4'h0 |-> chk_now == chk_data_r)
        else $error("36-bit full write did not store all bits");
    chk_lanes_36: assert property (@(posedge ref_clk) disable iff (!rst_sync_n) // R9 R10 R11
        chk_go_r && chk_org_r |-> (chk_now[8:0] == (chk_sel_r[0] ? chk_old_r[8:0] : chk_data_r[8:0]))
        && (chk_now[17:9] == (chk_sel_r[1] ? chk_old_r[17:9] : chk_data_r[17:9]))
        && (chk_now[26:18] == (chk_sel_r[2] ? chk_old_r[26:18] : chk_data_r[26:18]))
        && (chk_now[35:27] == (chk_sel_r[3] ? chk_old_r[35:27] : chk_data_r[35:27])))
        else $error("36-bit lane gating wrong");
    chk_none_36: assert property (@(posedge ref_clk) disable iff (!rst_sync_n) // R12
        chk_go_r && chk_org_r && chk_sel_r == 4'hF |-> chk_now == chk_old_r)
        else $error("36-bit beat with no selects changed the word");
    chk_beat_order: assert property (@(posedge ref_clk) disable iff (!rst_sync_n) // R14 R15
        beat0_go |=> phase_r == PH_SECOND ##0 (!beat_go || beat1_go) [*1])
        else $error("first beat did not arm the second beat");
    chk_own_selects: assert property (@(posedge ref_clk) disable iff (!rst_sync_n) // R7
        chk_second_r |-> chk_sel_r == $past(pin_s2_r.byte_lane_write_select_n))
        else $error("second beat used a stale select pattern");

endmodule // ddr_sram_write
`default_nettype wire

// ### dv/mem_ctrl_model.sv
// Memory controller model that drives the write bursts onto the SRAM pins.
`timescale 1ns/1ps
`default_nettype none
module mem_ctrl_model
    import ddr_sram_pkg::*;
(
    // Clock
    input  wire logic      ref_clk,
    // SRAM pins
    output var  mem_pins_t pins
);
    // K-high phases last 8 ref_clk with inputs moved mid-phase, 4 ref_clk from the edge; the K-low phase between a burst's two K rises lasts only 4.
    task automatic half();
        repeat (4) @(posedge ref_clk);
    endtask

    initial begin
        pins <= '{k: 1'b0, k_n: 1'b1, transfer_load_n: 1'b1, rw_n: 1'b1, addr: '0,
                  d: '0, byte_lane_write_select_n: '1};
    end

    task automatic burst(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d0,
                         input logic [LANES-1:0] s0, input logic [WORD_W-1:0] d1,
                         input logic [LANES-1:0] s1);
        @(posedge ref_clk);
        pins.transfer_load_n <= 1'b0;
        pins.rw_n            <= 1'b0;
        pins.addr            <= a;
        half();
        pins.k   <= 1'b1;
        pins.k_n <= 1'b0;
        half();
        // The address bus is released, so it shows the inverse of the held address.
        pins.transfer_load_n <= 1'b1;
        pins.rw_n            <= 1'b1;
        pins.addr            <= ~a;
        pins.d               <= d0;
        pins.byte_lane_write_select_n <= s0;
        half();
        pins.k   <= 1'b0;
        pins.k_n <= 1'b1;
        half();
        pins.k   <= 1'b1;
        pins.k_n <= 1'b0;
        half();
        pins.d   <= d1;
        pins.byte_lane_write_select_n <= s1;
        half();
        pins.k   <= 1'b0;
        pins.k_n <= 1'b1;
        half();
        pins.d   <= ~d1;
        pins.byte_lane_write_select_n <= ~s1;
        half();
    endtask
endmodule // mem_ctrl_model
`default_nettype wire

// ### dv/ddr_sram_byte_write_burst_tb.sv
// Self-checking testbench of the burst SRAM write side.
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin \
    compares++; \
    if ((got) !== (exp)) begin \
        num_errors++; \
        $display("Error at %0t: got %0h expected %0h", $time, got, exp); \
    end \
end
module ddr_sram_byte_write_burst_tb
    import ddr_sram_pkg::*;
;
    logic        ref_clk = 1'b0;
    logic        rst_n   = 1'b0;
    mem_pins_t   pins;
    logic        dq_oe;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata  = 32'h0;
    logic [31:0] rdata;
    logic        awvalid = 1'b0;
    logic        wvalid  = 1'b0;
    logic        bready  = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready  = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [35:0] mem_m [DEPTH];
    logic        org36_m = 1'b0;
    int          num_errors = 0;
    int          compares   = 0;

    always #10 ref_clk = ~ref_clk;

    mem_ctrl_model ctrl (.ref_clk(ref_clk), .pins(pins));

    ddr_sram_write uut (
        .ref_clk(ref_clk), .rst_n(rst_n), .pins(pins), .dq_oe(dq_oe),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready)
    );

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
        @(posedge ref_clk);
        awaddr  <= a;
        awvalid <= 1'b1;
        wdata   <= v;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        // Address and data are released independently, each as soon as it is taken.
        do begin
            @(posedge ref_clk);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
        end while (!((awvalid == 1'b0 || awready === 1'b1) && (wvalid == 1'b0 || wready === 1'b1)));
        while (bvalid !== 1'b1) @(posedge ref_clk);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        @(posedge ref_clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge ref_clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        while (rvalid !== 1'b1) @(posedge ref_clk);
        v = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    function automatic logic [35:0] merge(input logic [35:0] o, n, input logic [3:0] s);
        logic [35:0] m;
        m = '0;
        for (int l = 0; l < LANES; l++)
            if (!s[l] && (org36_m || l < LANES_18)) m[l*LANE_W +: LANE_W] = '1;
        return (o & ~m) | (n & m);
    endfunction

    task automatic check_word(input logic [ADDR_W-1:0] a);
        logic [31:0] v, vis;
        logic [1:0]  r;
        vis = org36_m ? 32'hFFFFFFFF : 32'h0003FFFF;
        axi_wr(PEEK_IDX_OFS, {28'h0, a}, r);
        `CHK(r, RESP_OKAY)
        axi_rd(PEEK_DAT_OFS, v, r);
        `CHK(r, RESP_OKAY)
        `CHK(v & vis, mem_m[a][31:0] & vis)
    endtask

    task automatic burst_check(input logic [ADDR_W-1:0] a, input logic [35:0] d0,
                               input logic [3:0] s0, input logic [35:0] d1,
                               input logic [3:0] s1);
        ctrl.burst(a, d0, s0, d1, s1);
        mem_m[a]     = merge(mem_m[a], d0, s0);
        mem_m[a ^ 1] = merge(mem_m[a ^ 1], d1, s1);
        check_word(a);
        check_word(a ^ 4'h1);
    endtask

    task automatic t_reset();
        logic [31:0] v;
        logic [1:0]  r;
        `CHK(dq_oe, 1'b0)
        axi_rd(STATUS_OFS, v, r);
        `CHK(v[STAT_DESEL_BIT], 1'b1)
    endtask

    task automatic t_org18();
        logic [1:0] r;
        org36_m = 1'b0;
        axi_wr(CTRL_OFS, 32'h0, r);
        burst_check(4'h2, 36'h0_0001_2345, 4'h0, 36'h0_0003_CDEF, 4'h0);
        burst_check(4'h2, 36'h0_0002_A5A5, 4'hE, 36'h0_0001_5A5A, 4'hD);
        burst_check(4'h3, 36'h0_0003_FFFF, 4'hF, 36'h0_0000_1111, 4'hC);
    endtask

    task automatic t_org36();
        logic [3:0] tbl [5];
        logic [1:0] r;
        tbl = '{4'hE, 4'hD, 4'hB, 4'h7, 4'hF};
        org36_m = 1'b1;
        axi_wr(CTRL_OFS, 32'h1, r);
        burst_check(4'h6, 36'h1_2345_6789, 4'h0, 36'h9_8765_4321, 4'h0);
        for (int i = 0; i < 5; i++)
            burst_check(4'h6 | 4'(i & 1), 36'hA_5A5A_5A5A ^ 36'(i), tbl[i],
                        36'h5_A5A5_A5A5 + 36'(i), tbl[(i + 2) % 5]);
    endtask

    task automatic t_unmapped();
        logic [31:0] v;
        logic [1:0]  r;
        axi_rd(8'h10, v, r);
        `CHK(r, RESP_SLVERR)
        `CHK(v, 32'h0)
        axi_wr(8'h14, 32'h1, r);
        `CHK(r, RESP_SLVERR)
        axi_rd(STATUS_OFS, v, r);
        `CHK(v[STAT_ORG36_BIT], 1'b1)
        // Nine bursts of two beats each have been sent, every one completed.
        `CHK(v[STAT_BEATS_LSB +: BEAT_CNT_W], 16'h0012)
        `CHK(v[STAT_PEND2_BIT], 1'b0)
        `CHK(v[STAT_DESEL_BIT], 1'b1)
        `CHK(dq_oe, 1'b0)
    endtask

    task automatic results();
        $display("Comparisons %0d, mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (5) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (5) @(posedge ref_clk);
        t_reset();
        t_org18();
        t_org36();
        t_unmapped();
        results();
    end

    // The whole sequence takes well under a thousand cycles, so this limit means a hang.
    initial begin
        repeat (40000) @(posedge ref_clk);
        num_errors++;
        results();
    end
endmodule // ddr_sram_byte_write_burst_tb
`default_nettype wire
